//--- sim/qsfi_host.sv
// Host model driving the flash interface pins
`timescale 1ns/1ps
module qsfi_host (
    input wire logic clk,
    output logic sck = 1'b0,
    output logic cs_n = 1'b1,
    output logic [3:0] io_in,
    input wire logic [3:0] dut_out,
    input wire logic [3:0] dut_oe,
    input wire logic guard_n
);
    // ****
    // Pin levels and frame tasks
    // ****
    logic quad = 1'b0;
    logic drv_en = 1'b0;
    logic [3:0] drv = 4'h0;
    always_comb begin
        for (int i = 0; i < 4; i++) io_in[i] = drv_en ? drv[i] : ~drv[i];
        if (!quad) io_in[2] = guard_n;
        if (!quad) io_in[3] = 1'b1;
        for (int i = 0; i < 4; i++) if (dut_oe[i]) io_in[i] = dut_out[i];
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    task automatic sel();
        @(posedge clk);
        cs_n <= 1'b0;
        half();
    endtask
    task automatic desel();
        half();
        cs_n <= 1'b1;
        drv_en <= 1'b0;
        half();
        half();
    endtask
    task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
        r = 8'h00;
        for (int k = 0; k < (quad ? 2 : 8); k++) begin
            sck <= 1'b0;
            if (quad) drv <= (k == 0) ? w[7:4] : w[3:0];
            else drv[0] <= w[7-k];
            drv_en <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            r = quad ? {r[3:0], io_in} : {r[6:0], io_in[1]};
            @(posedge clk);
            sck <= 1'b1;
            half();
        end
    endtask
endmodule

//--- sim/qsfi_monitor.sv
// Port checker for the flash interface core
`timescale 1ns/1ps
module qsfi_monitor #(
    parameter int ARRAY_AW = 21
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] quad_io_lines_out,
    input wire logic [3:0] quad_io_lines_oe,
    input wire logic [ARRAY_AW-1:0] mem_addr,
    input wire logic mem_sec,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_erase
);
    // ****
    // Cycles since serial clock fall
    // ****
    logic sck_d_r;
    logic [2:0] fall_cnt_r;
    always_ff @(posedge clk) begin
        sck_d_r <= sck;
        if (!resetn) fall_cnt_r <= 3'h7;
        else if (sck_d_r && !sck) fall_cnt_r <= 3'h0;
        else if (fall_cnt_r != 3'h7) fall_cnt_r <= fall_cnt_r + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_desel_float: assert property (cs_n [*4] |-> quad_io_lines_oe == 4'h0)
        else $error("lines driven while deselected");
    chk_oe_legal: assert property (quad_io_lines_oe inside {4'h0, 4'h2, 4'hf})
        else $error("bad output enable pattern");
    chk_out_fall: assert property ($changed(quad_io_lines_out) && !cs_n &&
        quad_io_lines_oe != 4'h0 && $past(quad_io_lines_oe) != 4'h0 |-> fall_cnt_r <= 3'h5)
        else $error("output moved away from a clock fall");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_erase_pulse: assert property (mem_erase |=> !mem_erase)
        else $error("erase strobe too long");
    chk_prog_pulse: assert property (mem_wr |=> !mem_wr)
        else $error("program strobe too long");
    chk_fetch_pulse: assert property (mem_rd |=> !mem_rd)
        else $error("fetch strobe too long");
    chk_uid_guard: assert property (mem_wr && mem_sec |-> mem_addr[10:0] >= 11'h008)
        else $error("unique id overwritten");
endmodule
bind qsfi_core qsfi_monitor #(.ARRAY_AW(ARRAY_AW)) u_mon (.clk(clk), .resetn(resetn),
    .sck(sck), .cs_n(cs_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .quad_io_lines_out(quad_io_lines_out), .quad_io_lines_oe(quad_io_lines_oe),
    .mem_addr(mem_addr), .mem_sec(mem_sec), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_erase(mem_erase));

//--- sim/tb_top.sv
// Self-checking bench for the flash interface core
`timescale 1ns/1ps
module tb_top;
    import qsfi_pkg::*;
    // ****
    // Signals, design, array model
    // ****
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic guard_n = 1'b1;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] reg_rdata, mem_wdata, d;
    logic sck, cs_n, mem_sec, mem_rd, mem_wr, mem_erase;
    logic [3:0] io_in, io_out, io_oe;
    logic [20:0] mem_addr;
    qsfi_esize_e mem_erase_size, erase_seen;
    logic [28:0] wr_log [0:1];
    logic [7:0] rx [0:3];
    logic [7:0] rst_exp [0:5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    int err_total = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    qsfi_core #(.ERASE_CNT(50), .PROG_CNT(20)) dut (.clk(clk), .resetn(resetn), .sck(sck),
        .cs_n(cs_n), .quad_io_lines_in(io_in), .quad_io_lines_out(io_out),
        .quad_io_lines_oe(io_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_sec(mem_sec),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_erase(mem_erase), .mem_erase_size(mem_erase_size));
    qsfi_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .io_in(io_in), .dut_out(io_out),
        .dut_oe(io_oe), .guard_n(guard_n));
    always @(posedge clk) begin
        if (mem_rd) mem_rdata <= mem_addr[7:0] ^ 8'ha5;
        if (mem_erase) erase_seen <= mem_erase_size;
        if (mem_wr) wr_log[0] <= wr_log[1];
        if (mem_wr) wr_log[1] <= {mem_addr, mem_wdata};
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] c, input logic [23:0] a, input int na, input int nd,
        input logic [31:0] wd);
        host.sel();
        host.xbyte(c, d);
        for (int i = 0; i < na; i++) host.xbyte(a[23-8*i -: 8], d);
        for (int i = 0; i < nd; i++) begin
            host.xbyte(wd[31-8*i -: 8], d);
            rx[i] = d;
        end
        host.desel();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100; i++) begin
            rreg(REG_STATUS);
            if (d[ST_BUSY] === 1'b0) break;
        end
        chk(d & 8'h01, 8'h00);
    endtask
    task automatic results();
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****
    // Test sequence
    // ****
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        foreach (rst_exp[i]) begin
            rreg(4'(i));
            chk(d, rst_exp[i]);
        end
        chk({4'h0, io_oe}, 8'h00);
        frame(CMD_READ, 24'h00a0ff, 3, 2, 0);
        chk(rx[0], 8'h5a);
        chk(rx[1], 8'ha5);
        frame(CMD_BURST_LEN, 0, 0, 1, 0);
        frame(CMD_READ_WRAP, 24'h000106, 3, 3, 0);
        chk(rx[1], 8'ha2);
        chk(rx[2], 8'ha5);
        frame(CMD_WREN, 0, 0, 0, 0);
        frame(CMD_SECT_ERASE, 24'h010000, 3, 0, 0);
        rreg(REG_STATUS);
        chk(d & 8'h01, 8'h01);
        wait_idle();
        chk({6'h0, erase_seen}, {6'h0, ES_4K});
        wreg(REG_CONFIG, 8'h02);
        guard_n <= 1'b0;
        frame(CMD_WREN, 0, 0, 0, 0);
        frame(CMD_WR_PROT, 0, 0, 2, 0);
        rreg(REG_PROT_LO);
        chk(d, 8'hff);
        guard_n <= 1'b1;
        frame(CMD_WREN, 0, 0, 0, 0);
        frame(CMD_WR_PROT, 0, 0, 2, 32'hff000000);
        rreg(REG_PROT_HI);
        chk(d, 8'hff);
        frame(CMD_READ, 24'h000010, 3, 1, 0);
        chk(rx[0], 8'h00);
        frame(CMD_WREN, 0, 0, 0, 0);
        frame(CMD_PROG, 24'h0020ff, 3, 2, 32'h11220000);
        wait_idle();
        chk(wr_log[0][7:0], 8'h11);
        chk(wr_log[1][15:8], 8'h00);
        frame(CMD_QUAD_ON, 0, 0, 0, 0);
        rreg(REG_STATUS);
        chk(d & 8'h80, 8'h80);
        host.quad = 1'b1;
        guard_n <= 1'b0;
        frame(CMD_WREN, 0, 0, 0, 0);
        frame(CMD_WR_PROT, 0, 0, 2, 0);
        rreg(REG_PROT_HI);
        chk(d, 8'h00);
        frame(CMD_RST_EN, 0, 0, 0, 0);
        frame(CMD_RST, 0, 0, 0, 0);
        rreg(REG_STATUS);
        chk(d & 8'h80, 8'h00);
        results();
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule

//--- src/qsfi_core.sv
// Serial flash command interface, device side
//
// Behaviour
// R1 - Sample input bits on serial clock rise
// R2 - Shift read data on serial clock fall
// R3 - Quad enable command switches to four-bit
// R4 - Single-bit mode after reset
// R5 - Select falling edge starts new command
// R6 - Host keeps select low whole command
// R7 - Guard pin and config bits block protection writes
// R8 - Guard and pause pins ignored in quad
// R9 - Pause low suspends communication, keeps command
// R10 - Host ties pause high when unused
// R11 - Linear and 8/16/32/64 wrapped burst reads
// R12 - Page program up to 256 bytes
// R13 - Busy flag shows program or erase
// R14 - Program or erase can be suspended
// R15 - Erase 4K sectors, 8K/32K/64K blocks
// R16 - Parameter block write and read protection
// R17 - 2 KByte security area, 64-bit ID
// R18 - Software reset restores mode defaults
// R19 - Works with clock idling low or high
// R20 - Read-locked blocks return zero bytes
// R21 - Deselected: ignore clock, float, discard
// R22 - Host avoids commands while busy
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module qsfi_core
    import qsfi_pkg::*;
#(
    parameter int ARRAY_AW = 21,
    parameter int ERASE_CNT = qsfi_pkg::ERASE_CYCLES,
    parameter int PROG_CNT = qsfi_pkg::PROG_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] quad_io_lines_in,
    output logic [3:0] quad_io_lines_out,
    output logic [3:0] quad_io_lines_oe,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [ARRAY_AW-1:0] mem_addr,
    output logic mem_sec,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic mem_erase,
    output qsfi_pkg::qsfi_esize_e mem_erase_size
);
    import qsfi_pkg::*;

    typedef enum {S_CMD, S_ADDR, S_DIN, S_DOUT, S_SKIP} qsfi_state_e;

    // ****************************************************************
    // Pin sampling and edge detection
    // ****************************************************************
    logic [5:0] syn;
    logic sck_s, cs_n_s, sck_d_r, cs_n_d_r;
    logic [3:0] io_s;
    logic quad_r, hold_act, act, rise, fall, frame_start, frame_end;

    qsfi_sync #(.W(6)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({sck, ~cs_n, quad_io_lines_in}),
        .q(syn)
    );
    assign sck_s = syn[5];
    assign cs_n_s = ~syn[4];
    assign io_s = syn[3:0];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    assign hold_act = ~quad_r & ~io_s[3]; // [R8] [R9]
    assign act = ~cs_n_s & ~hold_act; // [R21]
    assign rise = act & sck_s & ~sck_d_r; // [R19]
    assign fall = act & ~sck_s & sck_d_r;
    assign frame_start = ~cs_n_s & cs_n_d_r; // [R5]
    assign frame_end = cs_n_s & ~cs_n_d_r;

    // ****************************************************************
    // Input shifter
    // ****************************************************************
    qsfi_state_e state_r;
    logic [3:0] step, bit_cnt_r, ocnt_r;
    logic [7:0] sh_r, in_byte, cmd_r;
    logic byte_done;

    assign step = quad_r ? 4'h4 : 4'h1; // [R3] [R4]
    assign in_byte = quad_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
    assign byte_done = rise && ((bit_cnt_r + step) == 4'h8);

    always_ff @(posedge clk) begin
        if (!resetn || frame_start) begin
            bit_cnt_r <= 4'h0; // [R21]
            sh_r <= 8'h00;
        end else if (rise) begin
            bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + step;
            sh_r <= in_byte; // [R1]
        end
    end

    // ****************************************************************
    // Protection helpers
    // ****************************************************************
    logic [15:0] prot_r;
    logic [7:0] cfg_r;

    function automatic logic [3:0] param_blk(input logic [23:0] a);
        logic lo, hi;
        lo = (a[ARRAY_AW-1:15] == '0);
        hi = (a[ARRAY_AW-1:15] == '1);
        param_blk = {lo | hi, hi, a[14:13]};
    endfunction

    function automatic logic wlocked(input logic [23:0] a);
        logic [3:0] p;
        p = param_blk(a);
        wlocked = p[3] & prot_r[p[2:0]]; // [R16]
    endfunction

    function automatic logic rlocked(input logic [23:0] a);
        logic [3:0] p;
        p = param_blk(a);
        rlocked = p[3] & prot_r[{1'b1, p[2:0]}]; // [R16]
    endfunction

    function automatic qsfi_esize_e blk_size(input logic [23:0] a);
        logic [3:0] p;
        p = param_blk(a);
        if (p[3]) begin
            blk_size = ES_8K;
        end else if (a[ARRAY_AW-1:15] == 1 || a[ARRAY_AW-1:15] == {{(ARRAY_AW-16){1'b1}}, 1'b0}) begin
            blk_size = ES_32K;
        end else begin
            blk_size = ES_64K;
        end
    endfunction

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    logic [23:0] addr_r, addr_full;
    logic [1:0] abyte_r, wrap_r;
    logic dbyte_r, cmd_ok_r, busy_r, susp_r, wel_r, rst_en_r, prog_pend_r;
    logic ev_cmd, ev_addr, ev_din, exec, wp_block, ok_busy, ok_write, sw_rst;
    logic [7:0] prot_hi_r;

    assign ev_cmd = byte_done & (state_r == S_CMD);
    assign ev_addr = byte_done & (state_r == S_ADDR) & (abyte_r == 2'h2);
    assign ev_din = byte_done & (state_r == S_DIN);
    assign exec = frame_end & cmd_ok_r & (state_r == S_SKIP);
    assign addr_full = {addr_r[15:0], in_byte};
    assign ok_busy = ~busy_r | in_byte == CMD_RDSR | in_byte == CMD_SUSPEND; // [R13] [R22]
    assign ok_write = ~busy_r & ~susp_r;
    assign sw_rst = exec & (cmd_r == CMD_RST) & rst_en_r; // [R18]
    assign wp_block = ~quad_r & ~cfg_r[CFG_IOC] & cfg_r[CFG_GUARD_PIN_ENABLE] & ~io_s[2]; // [R7] [R8]

    always_ff @(posedge clk) begin
        if (!resetn || frame_start || frame_end) begin
            state_r <= S_CMD; // [R5] [R21]
            cmd_ok_r <= 1'b0;
            abyte_r <= 2'h0;
            dbyte_r <= 1'b0;
        end else if (ev_cmd) begin
            cmd_r <= in_byte;
            cmd_ok_r <= ok_busy;
            case (in_byte)
                CMD_READ, CMD_READ_WRAP, CMD_RD_SEC, CMD_PROG, CMD_PROG_SEC,
                CMD_SECT_ERASE, CMD_BLK_ERASE: begin
                    state_r <= ok_busy ? S_ADDR : S_SKIP;
                end
                CMD_WR_PROT, CMD_BURST_LEN: begin
                    state_r <= ok_busy ? S_DIN : S_SKIP;
                end
                CMD_RDSR, CMD_RD_PROT: begin
                    state_r <= ok_busy ? S_DOUT : S_SKIP;
                end
                default: begin
                    state_r <= S_SKIP;
                end
            endcase
        end else if (byte_done && state_r == S_ADDR) begin
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == 2'h2) begin
                case (cmd_r)
                    CMD_READ, CMD_READ_WRAP, CMD_RD_SEC: state_r <= S_DOUT;
                    CMD_PROG, CMD_PROG_SEC: state_r <= S_DIN;
                    default: state_r <= S_SKIP;
                endcase
            end
        end else if (ev_din) begin
            dbyte_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_r <= 24'h000000;
        end else if (byte_done && state_r == S_ADDR) begin
            addr_r <= addr_full;
        end else if (ev_din && (cmd_r == CMD_PROG || cmd_r == CMD_PROG_SEC)) begin
            addr_r <= (addr_r & ~MASK_PAGE) | ((addr_r + 24'h000001) & MASK_PAGE); // [R12]
        end
    end

    // ****************************************************************
    // Mode, enable latch, protection and config state
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn || sw_rst) begin
            quad_r <= 1'b0; // [R4] [R18]
            wrap_r <= WRAP_RST;
            rst_en_r <= 1'b0;
        end else begin
            if (exec) begin
                rst_en_r <= (cmd_r == CMD_RST_EN);
            end
            if (exec && cmd_r == CMD_QUAD_ON) begin
                quad_r <= 1'b1; // [R3]
            end else if (exec && cmd_r == CMD_QUAD_OFF) begin
                quad_r <= 1'b0;
            end
            if (ev_din && cmd_r == CMD_BURST_LEN) begin
                wrap_r <= in_byte[1:0]; // [R11]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || sw_rst) begin
            wel_r <= 1'b0;
        end else if (exec && cmd_r == CMD_WREN) begin
            wel_r <= 1'b1;
        end else if ((exec && (cmd_r == CMD_WRDI || cmd_r == CMD_SECT_ERASE
                     || cmd_r == CMD_BLK_ERASE)) || (frame_end && prog_pend_r)
                     || (ev_din && cmd_r == CMD_WR_PROT && dbyte_r)) begin
            wel_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prot_r <= PROT_RST;
            prot_hi_r <= 8'h00;
            cfg_r <= CFG_RST;
        end else begin
            if (ev_din && cmd_r == CMD_WR_PROT && !dbyte_r) begin
                prot_hi_r <= in_byte;
            end
            if (ev_din && cmd_r == CMD_WR_PROT && dbyte_r && wel_r && !wp_block) begin
                prot_r <= {prot_hi_r, in_byte}; // [R7] [R16]
            end
            if (reg_wr && reg_addr == REG_CONFIG) begin
                cfg_r <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Busy timer and suspend
    // ****************************************************************
    logic [31:0] busy_cnt_r;
    logic start_erase;

    assign start_erase = exec & (cmd_r == CMD_SECT_ERASE || cmd_r == CMD_BLK_ERASE)
                         & wel_r & ok_write & ~wlocked(addr_r); // [R15]

    always_ff @(posedge clk) begin
        if (!resetn || sw_rst) begin
            busy_r <= 1'b0;
            susp_r <= 1'b0;
            busy_cnt_r <= 32'h0;
        end else if (start_erase) begin
            busy_r <= 1'b1; // [R13]
            busy_cnt_r <= 32'(ERASE_CNT - 1);
        end else if (frame_end && prog_pend_r) begin
            busy_r <= 1'b1;
            busy_cnt_r <= 32'(PROG_CNT - 1);
        end else if (exec && cmd_r == CMD_SUSPEND && busy_r) begin
            busy_r <= 1'b0; // [R14]
            susp_r <= 1'b1;
        end else if (exec && cmd_r == CMD_RESUME && susp_r) begin
            busy_r <= 1'b1;
            susp_r <= 1'b0;
        end else if (busy_r) begin
            busy_r <= (busy_cnt_r != 32'h0);
            busy_cnt_r <= busy_cnt_r - 32'h1;
        end
    end

    // ****************************************************************
    // Array port
    // ****************************************************************
    logic [7:0] nb_r, status;
    logic load_ev, rd_vld_r, prot_sel_r, wr_ok;
    logic [23:0] rd_addr_r, rmask;

    always_comb begin
        status = 8'h00;
        status[ST_BUSY] = busy_r; // [R13]
        status[ST_WEL] = wel_r;
        status[ST_SUSP] = susp_r;
        status[ST_QUAD] = quad_r;
    end

    always_comb begin
        case (cmd_r)
            CMD_READ_WRAP: begin
                case (wrap_r)
                    2'h0: rmask = MASK_WRAP8; // [R11]
                    2'h1: rmask = MASK_WRAP16;
                    2'h2: rmask = MASK_WRAP32;
                    default: rmask = MASK_WRAP64;
                endcase
            end
            CMD_RD_SEC: rmask = MASK_SEC; // [R17]
            default: rmask = MASK_LINEAR;
        endcase
    end

    assign load_ev = fall & (state_r == S_DOUT) & (ocnt_r == 4'h0 || ocnt_r == 4'h8);
    assign wr_ok = wel_r & ok_write & (cmd_r == CMD_PROG ? ~wlocked(addr_r)
                                       : addr_r[10:0] >= SEC_UID_END[10:0]); // [R17]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_erase <= 1'b0;
            mem_sec <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 8'h00;
            mem_erase_size <= ES_4K;
            rd_addr_r <= 24'h000000;
            rd_vld_r <= 1'b0;
            prog_pend_r <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_erase <= 1'b0;
            rd_vld_r <= mem_rd;
            if (frame_start) begin
                prog_pend_r <= 1'b0;
            end
            if (ev_addr && (cmd_r == CMD_READ || cmd_r == CMD_READ_WRAP || cmd_r == CMD_RD_SEC)) begin
                mem_rd <= 1'b1;
                mem_sec <= (cmd_r == CMD_RD_SEC);
                rd_addr_r <= addr_full;
                mem_addr <= addr_full[ARRAY_AW-1:0];
            end else if (load_ev && cmd_r != CMD_RDSR && cmd_r != CMD_RD_PROT) begin
                mem_rd <= 1'b1; // [R11]
                rd_addr_r <= (rd_addr_r & ~rmask) | ((rd_addr_r + 24'h000001) & rmask);
                mem_addr <= ARRAY_AW'((rd_addr_r & ~rmask) | ((rd_addr_r + 24'h000001) & rmask));
            end else if (ev_din && (cmd_r == CMD_PROG || cmd_r == CMD_PROG_SEC) && wr_ok) begin
                mem_wr <= 1'b1; // [R12]
                mem_sec <= (cmd_r == CMD_PROG_SEC);
                mem_addr <= addr_r[ARRAY_AW-1:0];
                mem_wdata <= in_byte;
                prog_pend_r <= 1'b1;
            end else if (start_erase) begin
                mem_erase <= 1'b1; // [R15]
                mem_sec <= 1'b0;
                mem_addr <= addr_r[ARRAY_AW-1:0];
                mem_erase_size <= (cmd_r == CMD_SECT_ERASE) ? ES_4K : blk_size(addr_r);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || frame_start) begin
            nb_r <= 8'h00;
            prot_sel_r <= 1'b0;
        end else if (cmd_r == CMD_RDSR) begin
            nb_r <= status; // [R13]
        end else if (cmd_r == CMD_RD_PROT) begin
            nb_r <= prot_sel_r ? prot_r[7:0] : prot_r[15:8];
            prot_sel_r <= prot_sel_r ^ load_ev;
        end else if (rd_vld_r) begin
            nb_r <= (!mem_sec && rlocked(rd_addr_r)) ? 8'h00 : mem_rdata; // [R20]
        end
    end

    // ****************************************************************
    // Output shifter and pin drive
    // ****************************************************************
    logic [7:0] out_sh_r;

    always_ff @(posedge clk) begin
        if (!resetn || frame_start) begin
            ocnt_r <= 4'h0;
            out_sh_r <= 8'h00;
        end else if (load_ev) begin
            out_sh_r <= nb_r; // [R2]
            ocnt_r <= step;
        end else if (fall && state_r == S_DOUT) begin
            out_sh_r <= quad_r ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0}; // [R2]
            ocnt_r <= ocnt_r + step;
        end
    end

    assign quad_io_lines_out = quad_r ? out_sh_r[7:4] : {2'b00, out_sh_r[7], 1'b0};
    assign quad_io_lines_oe = (act && state_r == S_DOUT && ocnt_r != 4'h0)
                              ? (quad_r ? 4'hf : 4'h2) : 4'h0; // [R9] [R21]

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: reg_rdata <= status;
                REG_CONFIG: reg_rdata <= cfg_r;
                REG_PROT_LO: reg_rdata <= prot_r[7:0];
                REG_PROT_HI: reg_rdata <= prot_r[15:8];
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

//--- src/qsfi_pkg.sv
// Constants, command codes and register layout for the serial flash interface
package qsfi_pkg;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RDSR = 8'h05;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_READ_WRAP = 8'h0c;
    localparam logic [7:0] CMD_PROG = 8'h02;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLK_ERASE = 8'hd8;
    localparam logic [7:0] CMD_WR_PROT = 8'h42;
    localparam logic [7:0] CMD_RD_PROT = 8'h72;
    localparam logic [7:0] CMD_QUAD_ON = 8'h38;
    localparam logic [7:0] CMD_QUAD_OFF = 8'hff;
    localparam logic [7:0] CMD_RST_EN = 8'h66;
    localparam logic [7:0] CMD_RST = 8'h99;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BURST_LEN = 8'hc0;
    localparam logic [7:0] CMD_RD_SEC = 8'h88;
    localparam logic [7:0] CMD_PROG_SEC = 8'ha5;

    // ****************************************************************
    // Status and config bit positions, register offsets, reset values
    // ****************************************************************
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_SUSP = 2;
    localparam int ST_QUAD = 7;
    localparam int CFG_IOC = 0;
    localparam int CFG_GUARD_PIN_ENABLE = 1;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_PROT_LO = 4'h2;
    localparam logic [3:0] REG_PROT_HI = 4'h3;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] PROT_RST = 16'h00ff;

    // ****************************************************************
    // Address masks and sizes
    // ****************************************************************
    localparam logic [23:0] MASK_LINEAR = 24'hffffff;
    localparam logic [23:0] MASK_WRAP8 = 24'h000007;
    localparam logic [23:0] MASK_WRAP16 = 24'h00000f;
    localparam logic [23:0] MASK_WRAP32 = 24'h00001f;
    localparam logic [23:0] MASK_WRAP64 = 24'h00003f;
    localparam logic [23:0] MASK_PAGE = 24'h0000ff;
    localparam logic [23:0] MASK_SEC = 24'h0007ff;
    localparam logic [23:0] SEC_UID_END = 24'h000008;
    localparam logic [1:0] WRAP_RST = 2'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int ERASE_TIME_MS = 25;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * CLK_MHZ * 1000;
    localparam int PROG_CYCLES = 1000;

    typedef enum logic [1:0] {ES_4K, ES_8K, ES_32K, ES_64K} qsfi_esize_e;

endpackage

//--- src/qsfi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module qsfi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
